//--- logic/lpm_pkg.sv
// Functional notes
// - read latency selectable as 2 or 3
// - latency 3 data after n+2, else n+1
// - mode load needs upper address bits zero
// - controller never sends nonzero upper mode bits
// - extended config loaded with bank bits 10
// - extended config kept until rewrite or deep power-down
// - temperature bits ignored, sensor sets refresh rate
// - five partial refresh scopes
// - reads and writes always reach whole array
// - drive strength selects 25, 37, 55 ohms
// - status word reports maker, revision, multiplier, width, density
// - status load uses bank bits 01, address zero
// - status read only with all banks idle
// - wait setup interval with NOPs, then READ
// - NOPs until status completion interval ends
// - status read is two beats, second don't-care
// - status data uses programmed read latency
// - refresh interval is base times multiplier
// - ACTIVE before column command, wait row-to-column delay
// - same bank ACTIVE needs precharge and row cycle
// - other bank ACTIVE after bank-to-bank spacing
// - standard config loaded with bank bits 00
// - config loads with banks idle, then load delay
package lpm_pkg;
  localparam int DQ_W = 16;
  localparam int ADDR_W = 14;
  localparam int CLK_PS = 5000;
  localparam int MEM_WORDS = 16;

  // least time to whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // timing, in ns, then cycles
  localparam int ROW_TO_COLUMN_DELAY_NS = 15;
  localparam int BANK_TO_BANK_ACTIVATE_SPACING_NS = 10;
  localparam int ROW_CYCLE_TIME_NS = 55;
  localparam int CONFIG_LOAD_DELAY_NS = 10;
  localparam int STATUS_SETUP_INTERVAL_NS = 10;
  localparam int STATUS_COMPLETION_INTERVAL_NS = 10;
  localparam int BASE_REFRESH_INTERVAL_NS = 7800;
  localparam int RCD_CYC = cyc_min(ROW_TO_COLUMN_DELAY_NS);
  localparam int RRD_CYC = cyc_min(BANK_TO_BANK_ACTIVATE_SPACING_NS);
  localparam int RC_CYC = cyc_min(ROW_CYCLE_TIME_NS);
  localparam int MRD_CYC = cyc_min(CONFIG_LOAD_DELAY_NS);
  localparam int SRR_CYC = cyc_min(STATUS_SETUP_INTERVAL_NS);
  localparam int SRC_CYC = cyc_min(STATUS_COMPLETION_INTERVAL_NS);
  localparam int REFI_CYC = BASE_REFRESH_INTERVAL_NS * 1000 / CLK_PS;

  // commands as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // bank bits {bank_addr_bit1, bank_addr_bit0} of a load
  localparam logic [1:0] BA_STD = 2'h0;
  localparam logic [1:0] BA_SRR = 2'h1;
  localparam logic [1:0] BA_EXT = 2'h2;
  localparam int PRE_ALL_BIT = 10;

  // standard config: burst length, type, latency
  localparam int MR_W = 7;
  localparam int MR_CL_LSB = 4;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [6:0] MR_RST = 7'h32;

  // extended config fields
  localparam int EMR_W = 8;
  localparam int EMR_PARTIAL_ARRAY_REFRESH_LSB = 0;
  localparam int EMR_DS_LSB = 5;
  localparam logic [7:0] EMR_RST = 8'h00;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_HALF = 3'h1;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_QUARTER = 3'h2;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_EIGHTH = 3'h5;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SIXTEENTH = 3'h6;
  localparam logic [2:0] DS_HALF = 3'h1;
  localparam logic [2:0] DS_3Q = 3'h2;
  localparam logic [5:0] OHM_FULL = 6'h19;
  localparam logic [5:0] OHM_3Q = 6'h25;
  localparam logic [5:0] OHM_HALF = 6'h37;

  // status word layout; id values arbitrary
  localparam int SRR_MULT_LSB = 8;
  localparam logic [3:0] SRR_MAKER = 4'hA;
  localparam logic [3:0] SRR_REV = 4'h1;
  localparam logic SRR_WIDTH = 1'b0;
  localparam logic [3:0] SRR_DENSITY = 4'h5;

  // controller register map and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_SRR = 8'h14;
  localparam logic [7:0] REG_REFI = 8'h18;
  localparam int CTRL_BA_LSB = 4;
  localparam int STS_ERR = 2;

  // controller operation codes
  localparam logic [2:0] OP_MODE = 3'h0;
  localparam logic [2:0] OP_EXT = 3'h1;
  localparam logic [2:0] OP_STATUS = 3'h2;
  localparam logic [2:0] OP_ACT = 3'h3;
  localparam logic [2:0] OP_RD = 3'h4;
  localparam logic [2:0] OP_WR = 3'h5;
  localparam logic [2:0] OP_PRE = 3'h6;

  // latency in clocks from a standard config value
  function automatic logic [1:0] lat_of(input logic [6:0] mr);
    return (mr[MR_CL_LSB +: 3] == CL_2) ? 2'd2 : 2'd3;
  endfunction
endpackage

//--- logic/lpm_if.sv
`timescale 1ns/1ps
interface lpm_if;
  import lpm_pkg::*;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [ADDR_W-1:0] a;
  logic [DQ_W-1:0] dq_dev;
  logic dq_dev_oe_n;
  logic [DQ_W-1:0] dq_ctl;
  logic dq_ctl_oe_n;
  logic [DQ_W-1:0] dq;

  // resolved data bus level
  assign dq = !dq_dev_oe_n ? dq_dev : (!dq_ctl_oe_n ? dq_ctl : '0);

  modport dev(
    input cs_n, ras_n, cas_n, we_n, ba, a, dq,
    output dq_dev, dq_dev_oe_n
  );
  modport ctl(
    output cs_n, ras_n, cas_n, we_n, ba, a, dq_ctl, dq_ctl_oe_n,
    input dq
  );
endinterface

//--- logic/lpm_device.sv
`timescale 1ns/1ps
module lpm_device
  import lpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  lpm_if.dev link,
  input wire logic self_refresh,
  input wire logic deep_pd,
  input wire logic [2:0] refresh_mult,
  output logic [6:0] mode_q,
  output logic [7:0] ext_q,
  output logic [5:0] drive_ohms_q,
  output logic [3:0] refresh_bank_mask_q,
  output logic [1:0] refresh_row_zero_q,
  output logic cmd_err_q
);

  typedef struct packed {
    logic [MR_W-1:0] mode;
    logic [EMR_W-1:0] ext;
    logic [5:0] ohms;
    logic [3:0] bmask;
    logic [1:0] rowz;
    logic srr_arm;
    logic [3:0] open;
    logic [3:0][3:0] rcd;
    logic [3:0] rrd;
    logic p1v;
    logic p1s;
    logic [DQ_W-1:0] p1d;
    logic p2v;
    logic p2s;
    logic [DQ_W-1:0] p2d;
    logic beat2;
    logic [DQ_W-1:0] dq;
    logic oe_n;
    logic err;
  } lpm_dev_st_t;

  lpm_dev_st_t s_q;
  lpm_dev_st_t s_d;
  logic [DQ_W-1:0] mem [MEM_WORDS];
  logic sel;
  logic [2:0] cmd;
  logic [3:0] idx;
  logic [DQ_W-1:0] status_word;
  logic [2:0] partial_array_refresh;

  ////////////////////////////////////////////////////////////
  // command decode and status word
  assign sel = !link.cs_n;
  assign cmd = {link.ras_n, link.cas_n, link.we_n};
  assign idx = {link.ba, link.a[1:0]};
  assign status_word = {SRR_DENSITY, SRR_WIDTH, refresh_mult,
                        SRR_REV, SRR_MAKER};
  assign partial_array_refresh = s_q.ext[EMR_PARTIAL_ARRAY_REFRESH_LSB +: 3];

  ////////////////////////////////////////////////////////////
  // small array standing in for the cells
  always_ff @(posedge clk) begin
    if (sel && cmd == CMD_WR) begin
      mem[idx] <= link.dq;
    end
  end

  ////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.err = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (s_q.rcd[i] != 4'h0) begin
        s_d.rcd[i] = s_q.rcd[i] - 4'h1;
      end
    end
    if (s_q.rrd != 4'h0) begin
      s_d.rrd = s_q.rrd - 4'h1;
    end

    // output stage: one beat, or two for status
    s_d.oe_n = 1'b1;
    s_d.beat2 = 1'b0;
    s_d.dq = '0;
    if (s_q.beat2) begin
      s_d.oe_n = 1'b0; // don't-care second beat
    end
    s_d.p2v = 1'b0;
    if (s_q.p1v && lat_of(s_q.mode) == 2'd3) begin
      s_d.p2v = 1'b1; // extra stage for latency 3
      s_d.p2s = s_q.p1s;
      s_d.p2d = s_q.p1d;
    end
    if (s_q.p2v) begin
      s_d.oe_n = 1'b0; // edge n+2
      s_d.dq = s_q.p2d;
      s_d.beat2 = s_q.p2s;
    end else if (s_q.p1v && lat_of(s_q.mode) == 2'd2) begin
      s_d.oe_n = 1'b0; // edge n+1
      s_d.dq = s_q.p1d;
      s_d.beat2 = s_q.p1s;
    end
    s_d.p1v = 1'b0;

    // any other command cancels a pending status read
    if (sel && cmd != CMD_NOP && cmd != CMD_RD) begin
      s_d.srr_arm = 1'b0;
    end

    if (sel) begin
      unique case (cmd)
        CMD_LMR: begin
          unique case (link.ba)
            BA_STD: begin
              if (link.a[ADDR_W-1:MR_W] == '0) begin
                s_d.mode = link.a[MR_W-1:0];
              end
            end
            BA_EXT: begin
              s_d.ext = link.a[EMR_W-1:0]; // temp bits stored, unused
              unique case (link.a[EMR_DS_LSB +: 3])
                DS_HALF: s_d.ohms = OHM_HALF;
                DS_3Q: s_d.ohms = OHM_3Q;
                default: s_d.ohms = OHM_FULL;
              endcase
            end
            BA_SRR: begin
              s_d.srr_arm = (link.a == '0);
            end
            default: begin
              s_d.srr_arm = 1'b0; // reserved load ignored
            end
          endcase
        end
        CMD_ACT: begin
          if (s_q.rrd != 4'h0 || s_q.open[link.ba]) begin
            s_d.err = 1'b1; // spacing or open row broken
          end
          s_d.open[link.ba] = 1'b1;
          s_d.rcd[link.ba] = 4'(RCD_CYC - 1); // column legal RCD_CYC edges later
          s_d.rrd = 4'(RRD_CYC - 1);
        end
        CMD_RD, CMD_WR: begin
          if (!s_q.srr_arm && (!s_q.open[link.ba] || s_q.rcd[link.ba] != 4'h0)) begin
            s_d.err = 1'b1; // closed bank or too early
          end
          if (cmd == CMD_RD) begin
            s_d.p1v = 1'b1;
            s_d.p1s = s_q.srr_arm;
            s_d.p1d = s_q.srr_arm ? status_word : mem[idx];
            s_d.srr_arm = 1'b0;
          end
        end
        CMD_PRE: begin
          if (link.a[PRE_ALL_BIT]) begin
            s_d.open = 4'h0;
          end else begin
            s_d.open[link.ba] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // self refresh scope from partial-array setting
    s_d.bmask = 4'hF;
    s_d.rowz = 2'h0;
    if (self_refresh) begin
      unique case (partial_array_refresh)
        PARTIAL_ARRAY_REFRESH_HALF: s_d.bmask = 4'h3;
        PARTIAL_ARRAY_REFRESH_QUARTER: s_d.bmask = 4'h1;
        PARTIAL_ARRAY_REFRESH_EIGHTH: begin
          s_d.bmask = 4'h1;
          s_d.rowz = 2'h1;
        end
        PARTIAL_ARRAY_REFRESH_SIXTEENTH: begin
          s_d.bmask = 4'h1;
          s_d.rowz = 2'h3;
        end
        default: s_d.bmask = 4'hF; // full array
      endcase
    end

    // deep power-down loses both configs
    if (deep_pd) begin
      s_d.mode = MR_RST;
      s_d.ext = EMR_RST;
      s_d.ohms = OHM_FULL;
      s_d.open = 4'h0;
      s_d.srr_arm = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.mode <= MR_RST;
      s_q.ext <= EMR_RST;
      s_q.ohms <= OHM_FULL;
      s_q.bmask <= 4'hF;
      s_q.oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs straight from the state
  assign link.dq_dev = s_q.dq;
  assign link.dq_dev_oe_n = s_q.oe_n;
  assign mode_q = s_q.mode;
  assign ext_q = s_q.ext;
  assign drive_ohms_q = s_q.ohms;
  assign refresh_bank_mask_q = s_q.bmask;
  assign refresh_row_zero_q = s_q.rowz;
  assign cmd_err_q = s_q.err;

endmodule

//--- logic/lpm_ctrl.sv
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module lpm_ctrl
  import lpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  lpm_if.ctl link,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  typedef enum logic [2:0] {S_IDLE, S_HOLD, S_SRR_WAIT, S_DRAIN} lpm_ctl_state_t;

  typedef struct packed {
    lpm_ctl_state_t st;
    logic [2:0] op;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] wdata;
    logic [2:0] cmd;
    logic cs_n;
    logic [1:0] pin_ba;
    logic [ADDR_W-1:0] pin_a;
    logic [DQ_W-1:0] dq;
    logic oe_n;
    logic [7:0] wait_c;
    logic [1:0] lat;
    logic [1:0] cap_c;
    logic cap_pend;
    logic cap_srr;
    logic [DQ_W-1:0] rdata;
    logic [DQ_W-1:0] status_read_register;
    logic [15:0] refi;
    logic valid;
    logic err;
    logic [3:0] open;
    logic [3:0][3:0] rcd;
    logic [3:0][3:0] rc;
    logic [3:0] rrd;
    logic [31:0] rdout;
  } lpm_ctl_st_t;

  lpm_ctl_st_t s_q;
  lpm_ctl_st_t s_d;

  ////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.cs_n = 1'b0;
    s_d.cmd = CMD_NOP;
    s_d.oe_n = 1'b1;
    s_d.rdout = '0;
    for (int i = 0; i < 4; i++) begin
      if (s_q.rcd[i] != 4'h0) s_d.rcd[i] = s_q.rcd[i] - 4'h1;
      if (s_q.rc[i] != 4'h0) s_d.rc[i] = s_q.rc[i] - 4'h1;
    end
    if (s_q.rrd != 4'h0) s_d.rrd = s_q.rrd - 4'h1;

    // read data capture after the programmed latency
    if (s_q.cap_c != 2'h0) s_d.cap_c = s_q.cap_c - 2'h1;
    if (s_q.cap_pend && s_q.cap_c == 2'h0) begin
      s_d.cap_pend = 1'b0;
      if (s_q.cap_srr) begin
        s_d.status_read_register = link.dq; // first beat only
        s_d.refi = 16'(REFI_CYC * int'(link.dq[SRR_MULT_LSB +: 3]));
      end else begin
        s_d.rdata = link.dq;
      end
    end

    // register reads, side effects on valid
    if (reg_rd) begin
      unique case (reg_addr)
        REG_ADDR: s_d.rdout = 32'(s_q.addr);
        REG_WDATA: s_d.rdout = 32'(s_q.wdata);
        REG_STATUS: s_d.rdout = {29'h0, s_q.err, s_q.valid, s_q.st != S_IDLE || s_q.cap_pend};
        REG_RDATA: s_d.rdout = 32'(s_q.rdata);
        REG_SRR: s_d.rdout = 32'(s_q.status_read_register);
        REG_REFI: s_d.rdout = 32'(s_q.refi);
        default: s_d.rdout = '0;
      endcase
      if (reg_addr == REG_RDATA) s_d.valid = 1'b0;
    end
    if (s_q.cap_pend && s_q.cap_c == 2'h0) s_d.valid = 1'b1;

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        REG_ADDR: s_d.addr = reg_wdata[ADDR_W-1:0];
        REG_WDATA: s_d.wdata = reg_wdata[DQ_W-1:0];
        REG_STATUS: if (reg_wdata[STS_ERR]) s_d.err = 1'b0;
        REG_CTRL: begin
          if (s_q.st == S_IDLE) begin
            s_d.op = reg_wdata[2:0];
            s_d.ba = reg_wdata[CTRL_BA_LSB +: 2];
            s_d.st = S_HOLD;
          end else begin
            s_d.err = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    unique case (s_q.st)
      S_IDLE: begin
      end
      S_HOLD: begin
        unique case (s_q.op)
          OP_MODE, OP_EXT, OP_STATUS: begin
            if (s_q.open != 4'h0 || s_q.cap_pend) begin
              s_d.err = 1'b1; // banks busy
              s_d.st = S_IDLE;
            end else begin
              s_d.cmd = CMD_LMR;
              s_d.wait_c = 8'(MRD_CYC - 1);
              s_d.st = S_DRAIN;
              if (s_q.op == OP_MODE) begin
                s_d.pin_ba = BA_STD;
                s_d.pin_a = {7'h0, s_q.addr[MR_W-1:0]};
                s_d.lat = lat_of(s_q.addr[MR_W-1:0]);
              end else if (s_q.op == OP_EXT) begin
                s_d.pin_ba = BA_EXT;
                s_d.pin_a = s_q.addr;
              end else begin
                s_d.pin_ba = BA_SRR;
                s_d.pin_a = '0;
                s_d.wait_c = 8'(SRR_CYC - 1);
                s_d.st = S_SRR_WAIT;
              end
            end
          end
          OP_ACT: begin
            if (s_q.open[s_q.ba]) begin
              s_d.err = 1'b1; // precharge first
              s_d.st = S_IDLE;
            end else if (s_q.rrd == 4'h0 && s_q.rc[s_q.ba] == 4'h0) begin
              s_d.cmd = CMD_ACT;
              s_d.pin_ba = s_q.ba;
              s_d.pin_a = s_q.addr;
              s_d.open[s_q.ba] = 1'b1;
              s_d.rcd[s_q.ba] = 4'(RCD_CYC);
              s_d.rc[s_q.ba] = 4'(RC_CYC);
              s_d.rrd = 4'(RRD_CYC);
              s_d.st = S_IDLE;
            end
          end
          OP_RD, OP_WR: begin
            if (!s_q.open[s_q.ba]) begin
              s_d.err = 1'b1; // no open row
              s_d.st = S_IDLE;
            end else if (s_q.rcd[s_q.ba] == 4'h0 && !s_q.cap_pend) begin
              s_d.cmd = (s_q.op == OP_RD) ? CMD_RD : CMD_WR;
              s_d.pin_ba = s_q.ba;
              s_d.pin_a = s_q.addr;
              s_d.dq = s_q.wdata;
              s_d.oe_n = (s_q.op == OP_RD);
              s_d.cap_pend = (s_q.op == OP_RD);
              s_d.cap_srr = 1'b0;
              s_d.cap_c = s_q.lat;
              s_d.st = S_IDLE;
            end
          end
          OP_PRE: begin
            s_d.cmd = CMD_PRE;
            s_d.pin_ba = s_q.ba;
            s_d.pin_a = s_q.addr;
            if (s_q.addr[PRE_ALL_BIT]) s_d.open = 4'h0;
            else s_d.open[s_q.ba] = 1'b0;
            s_d.st = S_IDLE;
          end
          default: begin
            s_d.err = 1'b1;
            s_d.st = S_IDLE;
          end
        endcase
      end
      S_SRR_WAIT: begin
        if (s_q.wait_c == 8'h0) begin
          s_d.cmd = CMD_RD;
          s_d.pin_a = '0;
          s_d.pin_ba = 2'h0;
          s_d.cap_pend = 1'b1;
          s_d.cap_srr = 1'b1;
          s_d.cap_c = s_q.lat;
          s_d.wait_c = 8'(SRC_CYC - 1);
          s_d.st = S_DRAIN;
        end else begin
          s_d.wait_c = s_q.wait_c - 8'h1;
        end
      end
      S_DRAIN: begin
        if (s_q.wait_c == 8'h0) s_d.st = S_IDLE;
        else s_d.wait_c = s_q.wait_c - 8'h1; // NOPs only
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.cs_n <= 1'b1;
      s_q.cmd <= CMD_NOP;
      s_q.oe_n <= 1'b1;
      s_q.lat <= 2'd3;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////
  // pins and read data from the state
  assign link.cs_n = s_q.cs_n;
  assign {link.ras_n, link.cas_n, link.we_n} = s_q.cmd;
  assign link.ba = s_q.pin_ba;
  assign link.a = s_q.pin_a;
  assign link.dq_ctl = s_q.dq;
  assign link.dq_ctl_oe_n = s_q.oe_n;
  assign reg_rdata = s_q.rdout;

endmodule

//--- testbench/lpm_assertions.sv
`timescale 1ns/1ps
module lpm_assertions
  import lpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [ADDR_W-1:0] a,
  input wire logic [DQ_W-1:0] dq_dev,
  input wire logic dq_dev_oe_n
);
  logic [2:0] cmd;
  logic lmr;
  logic rd;
  logic wr;
  logic act;
  logic nop;
  logic lat2_q;
  logic lat2_d;
  logic [3:0] open_q;
  logic [3:0] open_d;

  // decoded command, deselect counts as no-op
  assign cmd = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
  assign lmr = cmd == CMD_LMR;
  assign rd = cmd == CMD_RD;
  assign wr = cmd == CMD_WR;
  assign act = cmd == CMD_ACT;
  assign nop = cmd == CMD_NOP;

  // shadow of open banks and of the read latency
  always_comb begin
    open_d = open_q;
    lat2_d = lat2_q;
    if (act) open_d[ba] = 1'b1;
    if (cmd == CMD_PRE) open_d = a[PRE_ALL_BIT] ? 4'h0 : open_q & ~(4'h1 << ba);
    if (lmr && ba == BA_STD && a[13:7] == '0) lat2_d = a[6:4] == CL_2;
  end

  // shadow registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      open_q <= 4'h0;
      lat2_q <= 1'b0;
    end else begin
      open_q <= open_d;
      lat2_q <= lat2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_srr_load;
    lmr && ba == BA_SRR;
  endsequence
  sequence s_srr_read;
    s_srr_load ##1 nop ##1 rd;
  endsequence

  a_read_lat_two: assert property (rd && lat2_q |=> dq_dev_oe_n ##1 !dq_dev_oe_n)
    else $error("read data not one cycle after read");
  a_read_lat_three: assert property (rd && !lat2_q |=> dq_dev_oe_n [*2] ##1 !dq_dev_oe_n)
    else $error("read data not two cycles after read");
  a_mode_upper_zero: assert property (lmr && ba == BA_STD |-> a[13:7] == '0)
    else $error("mode load with upper bits set");
  a_status_addr_zero: assert property (s_srr_load |-> a == '0 && open_q == 4'h0)
    else $error("status load with address or open bank");
  a_status_setup: assert property (s_srr_load |=> nop ##1 rd)
    else $error("status setup gap broken");
  a_status_done: assert property (s_srr_read |=> nop)
    else $error("command inside status completion");
  a_status_beats: assert property (s_srr_read ##0 !lat2_q |=> dq_dev_oe_n [*2] ##1
    (!dq_dev_oe_n && dq_dev[7:0] == {SRR_REV, SRR_MAKER}) ##1 (!dq_dev_oe_n && dq_dev == '0))
    else $error("status beats wrong");
  a_load_idle: assert property (lmr |-> open_q == 4'h0)
    else $error("load with a bank open");
  a_col_open: assert property ((wr || rd && !$past(lmr, 2)) |-> open_q[ba])
    else $error("column command to closed bank");
  a_act_rcd: assert property (act |=> !(rd || wr) [*2])
    else $error("column command too soon after activate");
  a_act_rrd: assert property (act |=> !act)
    else $error("activates too close");
endmodule

//--- testbench/lpddr_mode_status_and_activation_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module lpddr_mode_status_and_activation_bench;
  import lpm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic self_refresh = 1'b0;
  logic deep_pd = 1'b0;
  logic [2:0] refresh_mult = 3'h0;
  logic [6:0] mode_q;
  logic [7:0] ext_q;
  logic [5:0] drive_ohms_q;
  logic [3:0] refresh_bank_mask_q;
  logic [1:0] refresh_row_zero_q;
  logic dev_err;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [2:0] ps_tab [5] = '{3'h0, PARTIAL_ARRAY_REFRESH_HALF, PARTIAL_ARRAY_REFRESH_QUARTER, PARTIAL_ARRAY_REFRESH_EIGHTH, PARTIAL_ARRAY_REFRESH_SIXTEENTH};
  logic [2:0] ds_tab [5] = '{3'h0, DS_HALF, DS_3Q, 3'h0, 3'h0};
  logic [3:0] mk_tab [5] = '{4'hF, 4'h3, 4'h1, 4'h1, 4'h1};
  logic [1:0] rz_tab [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
  logic [5:0] oh_tab [5] = '{OHM_FULL, OHM_HALF, OHM_3Q, OHM_FULL, OHM_FULL};

  lpm_if lpm_if_i();
  lpm_device lpm_device_i(.clk(clk), .rst(rst), .link(lpm_if_i), .self_refresh(self_refresh),
    .deep_pd(deep_pd), .refresh_mult(refresh_mult), .mode_q(mode_q), .ext_q(ext_q),
    .drive_ohms_q(drive_ohms_q), .refresh_bank_mask_q(refresh_bank_mask_q),
    .refresh_row_zero_q(refresh_row_zero_q), .cmd_err_q(dev_err));
  lpm_ctrl lpm_ctrl_i(.clk(clk), .rst(rst), .link(lpm_if_i), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  lpm_assertions lpm_assertions_i(.clk(clk), .rst(rst), .cs_n(lpm_if_i.cs_n),
    .ras_n(lpm_if_i.ras_n), .cas_n(lpm_if_i.cas_n), .we_n(lpm_if_i.we_n), .ba(lpm_if_i.ba),
    .a(lpm_if_i.a), .dq_dev(lpm_if_i.dq_dev), .dq_dev_oe_n(lpm_if_i.dq_dev_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask

  // launch one operation and poll until idle
  task automatic run(input logic [2:0] o, input logic [1:0] b, input logic [13:0] ad,
                     input logic [15:0] d);
    logic [31:0] s;
    wr(REG_ADDR, 32'(ad));
    wr(REG_WDATA, 32'(d));
    wr(REG_CTRL, {26'h0, b, 1'b0, o});
    s = 32'h1;
    for (int n = 0; n < 50 && s[0] !== 1'b0; n++) rd(REG_STATUS, s);
    `CHK("idle", 1'b0, s[0])
  endtask

  // expect a refused operation, then clear the flag
  task automatic refused(input string nm);
    logic [31:0] s;
    rd(REG_STATUS, s);
    `CHK(nm, 1'b1, s[STS_ERR])
    wr(REG_STATUS, 32'h4);
  endtask

  task automatic wrap_up();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // hang guard and device error watch
  always @(posedge clk) begin
    cycles++;
    if (dev_err !== 1'b0 && !rst) `CHK("dev_err", 1'b0, dev_err)
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    logic [31:0] v;
    logic [15:0] d;
    logic [2:0] m;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("mode_rst", MR_RST, mode_q)
    `CHK("ext_rst", EMR_RST, ext_q)
    `CHK("mask_rst", 4'hF, refresh_bank_mask_q)
    // extended loads with temperature bits set
    self_refresh <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      run(OP_EXT, BA_EXT, {6'h0, ds_tab[k], 2'h3, ps_tab[k]}, 16'h0);
      `CHK("ext", {ds_tab[k], 2'h3, ps_tab[k]}, ext_q)
      `CHK("ohms", oh_tab[k], drive_ohms_q)
      `CHK("mask", mk_tab[k], refresh_bank_mask_q)
      `CHK("rows", rz_tab[k], refresh_row_zero_q)
    end
    // both latencies: status read, then write and read back on bank 3
    for (int i = 0; i < 2; i++) begin
      m = i ? 3'h5 : 3'h2;
      d = 16'hA5C0 ^ 16'(i);
      refresh_mult <= m;
      run(OP_MODE, BA_STD, i ? 14'h0032 : 14'h0022, 16'h0);
      `CHK("mode", i ? 7'h32 : 7'h22, mode_q)
      run(OP_STATUS, BA_SRR, 14'h0, 16'h0);
      rd(REG_SRR, v);
      `CHK("status", {16'h0, SRR_DENSITY, SRR_WIDTH, m, SRR_REV, SRR_MAKER}, v)
      rd(REG_REFI, v);
      `CHK("refi", 32'(REFI_CYC * m), v)
      run(OP_ACT, 2'h3, 14'h0100, 16'h0);
      run(OP_WR, 2'h3, 14'(i), d);
      run(OP_RD, 2'h3, 14'(i), 16'h0);
      rd(REG_RDATA, v);
      `CHK("rdata", {16'h0, d}, v)
      run(OP_PRE, 2'h3, 14'h0400, 16'h0);
    end
    // refused operations
    run(OP_ACT, 2'h1, 14'h0, 16'h0);
    run(OP_ACT, 2'h1, 14'h0, 16'h0);
    refused("act_open");
    run(OP_MODE, BA_STD, 14'h0022, 16'h0);
    refused("load_open");
    `CHK("mode_kept", 7'h32, mode_q)
    run(OP_RD, 2'h2, 14'h0, 16'h0);
    refused("rd_closed");
    run(OP_PRE, 2'h0, 14'h0400, 16'h0);
    rd(8'hFC, v);
    `CHK("unmapped", 32'h0, v)
    // deep power-down drops the configuration
    `CHK("ext_kept", {3'h0, 2'h3, PARTIAL_ARRAY_REFRESH_SIXTEENTH}, ext_q)
    deep_pd <= 1'b1;
    @(posedge clk);
    deep_pd <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("ext_dpd", EMR_RST, ext_q)
    `CHK("mode_dpd", MR_RST, mode_q)
    wrap_up();
  end
endmodule
